//--- rtl/tbs_transmitter.sv
// Ten-bit serial transmitter: word capture, serializer, output steering.
`timescale 1ns/1ps
module tbs_transmitter (
  // Bit clock domain (multiplier output) and its reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Parallel word interface from the line coder
  input  wire logic                      word_strobe_clock,
  input  wire logic [tbs_pkg::WORD_W-1:0] tx_word,
  output logic                           word_rate_clock_out,
  // Rate and reference
  input  wire logic                      reference_clock,
  input  wire logic                      rate_choice,
  output logic                           ref_locked,
  output logic [7:0]                     ref_ratio,
  // Serial outputs
  input  wire logic                      loopback_select,
  output tbs_pkg::tbs_pair_s             line_out_pair,
  output tbs_pkg::tbs_pair_s             loopback_out_pair,
  // Signal-present translator
  input  wire tbs_pkg::tbs_pair_s        signal_present_in_pair,
  output logic                           signal_present_out
);
  import tbs_pkg::*;

  // ==========================================================================
  // Word strobe domain
  // The coder's clock may stop between frames, so this domain only captures
  // and flags; everything else lives on the bit clock.
  logic [1:0]        lrst_sync_q;
  logic              lrst_n;
  logic [WORD_W-1:0] cap_word_q;
  logic              cap_tgl_q;

  // The link reset is rst_n through two flops, so it releases a couple of
  // strobe edges after the bit clock domain does.
  always_ff @(posedge word_strobe_clock) begin
    lrst_sync_q <= {lrst_sync_q[0], rst_n};
  end
  assign lrst_n = lrst_sync_q[1];

  always_ff @(posedge word_strobe_clock) begin
    if (!lrst_n) begin
      cap_word_q <= IDLE_WORD;
    end else begin
      cap_word_q <= tx_word;
    end
  end

  always_ff @(posedge word_strobe_clock) begin
    if (!lrst_n) begin
      cap_tgl_q <= 1'b0;
    end else begin
      cap_tgl_q <= ~cap_tgl_q;
    end
  end

  // ==========================================================================
  // Crossings into the bit clock domain
  logic [1:0] tgl_sync_q;
  logic       tgl_seen_q;
  logic       new_word;
  logic [1:0] rate_sync_q;
  logic [1:0] loop_sync_q;
  logic [1:0] ref_sync_q;
  logic       ref_prev_q;

  // Each synchroniser is its own pair of flops; only the second stage is read.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tgl_sync_q <= 2'b00;
    end else begin
      tgl_sync_q <= {tgl_sync_q[0], cap_tgl_q};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rate_sync_q <= 2'b00;
    end else begin
      rate_sync_q <= {rate_sync_q[0], rate_choice};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loop_sync_q <= 2'b00;
    end else begin
      loop_sync_q <= {loop_sync_q[0], loopback_select};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_sync_q <= 2'b00;
    end else begin
      ref_sync_q <= {ref_sync_q[0], reference_clock};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tgl_seen_q <= 1'b0;
    end else begin
      tgl_seen_q <= tgl_sync_q[1];
    end
  end

  // The captured word is stable for a whole strobe period, far longer than
  // the two-stage toggle delay, so it is safe to read once the toggle lands.
  assign new_word = tgl_sync_q[1] ^ tgl_seen_q;

  // ==========================================================================
  // Reference clock monitor
  // The multiplier itself is analogue; here the bit clock stands for its
  // output and the ratio to the reference is measured to report lock.
  logic [7:0] ref_cnt_q;
  logic       ref_rise;

  assign ref_rise = ref_sync_q[1] & ~ref_prev_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_sync_q[1];
    end
  end

  // The counter saturates, so a reference that pauses reads as a large ratio at its
  // next rise and drops lock instead of wrapping back into range.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_cnt_q <= 8'h01;
    end else if (ref_rise) begin
      ref_cnt_q <= 8'h01;
    end else if (ref_cnt_q != RATIO_MAX) begin
      ref_cnt_q <= ref_cnt_q + 8'h01;
    end
  end

  // Bit clock to reference ratio check.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_ratio <= 8'h00;
    end else if (ref_rise) begin
      ref_ratio <= ref_cnt_q;
    end
  end

  // Lock only on an exact ratio of forty.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_locked <= 1'b0;
    end else if (ref_rise) begin
      ref_locked <= (ref_cnt_q == BITS_PER_REF);
    end
  end

  // ==========================================================================
  // Bit pacing and word counter
  // At the lower rate each bit is held for two bit clock cycles rather than
  // gating the clock, which keeps a single clock tree.
  // A rate change is only clean across a reset; changing it mid-word may
  // stretch or shorten one bit.
  logic             half_rate;
  logic             phase_q;
  logic             bit_step;
  logic [CNT_W-1:0] bit_idx_q;
  logic             word_end;

  // Rate choice high halves the baud.
  assign half_rate = rate_sync_q[1];
  assign bit_step  = ~half_rate | phase_q;
  assign word_end  = bit_step & (bit_idx_q == LAST_BIT_IDX);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= half_rate & ~phase_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_idx_q <= '0;
    end else if (word_end) begin
      bit_idx_q <= '0;
    end else if (bit_step) begin
      bit_idx_q <= bit_idx_q + 4'h1;
    end
  end

  // ==========================================================================
  // Holding register and start-up state
  tbs_state_e        state_q;
  logic [WORD_W-1:0] hold_word_q;

  // A word that lands on the cycle of a word boundary misses that load and
  // goes out one word later; a word is never split across two loads.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_word_q <= IDLE_WORD;
    end else if (new_word) begin
      hold_word_q <= cap_word_q;
    end
  end

  // Until the first word arrives the shifter sends the idle word, so the far
  // receiver sees a steady pattern rather than stale data.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= TBS_WAIT;
    end else begin
      case (state_q)
        TBS_WAIT: begin
          if (new_word) begin
            state_q <= TBS_RUN;
          end
        end
        TBS_RUN: begin
          state_q <= TBS_RUN;
        end
        default: begin
          state_q <= TBS_WAIT;
        end
      endcase
    end
  end

  // ==========================================================================
  // Serializer
  // If the coder misses a strobe the last word is resent; the line must
  // never stall once the serial stream has started.
  logic [WORD_W-1:0] shift_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_q <= IDLE_WORD;
    end else if (word_end) begin
      shift_q <= (state_q == TBS_RUN) ? hold_word_q : IDLE_WORD;
    end else if (bit_step) begin
      shift_q <= {shift_q[WORD_W-2:0], 1'b0};
    end
  end

  // Registered so the coder sees a clean clock: five bit periods high, then
  // five low, with the rise marking the first bit of each word.
  // Word clock from the serializer counter.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      word_rate_clock_out <= 1'b0;
    end else begin
      word_rate_clock_out <= (bit_idx_q < HALF_WORD_IDX);
    end
  end

  // ==========================================================================
  // Output steering
  // Both pairs switch on one edge from one synchronised select, so there is
  // never a cycle in which both carry data.
  logic serial_bit;
  logic loop_on;

  assign serial_bit = shift_q[WORD_W-1];
  assign loop_on    = loop_sync_q[1];

  // Differential drive of one serial bit.
  function automatic tbs_pair_s drive_pair(input logic bit_val);
    return '{p: bit_val, n: ~bit_val};
  endfunction : drive_pair

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_out_pair <= PAIR_IDLE;
    end else if (!loop_on) begin
      line_out_pair <= drive_pair(serial_bit);
    end else begin
      line_out_pair <= PAIR_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loopback_out_pair <= PAIR_IDLE;
    end else if (loop_on) begin
      loopback_out_pair <= drive_pair(serial_bit);
    end else begin
      loopback_out_pair <= PAIR_IDLE;
    end
  end

  // ==========================================================================
  // Signal-present translator
  // Unclocked pass-through of the pair.
  assign signal_present_out = signal_present_in_pair.p & ~signal_present_in_pair.n;

endmodule : tbs_transmitter

//--- rtl/tbs_pkg.sv
// Constants, types and operation summary for the ten-bit serial transmitter.
// Operation
// - Capture the whole 10-bit word on each word strobe clock rising edge.
// - Shift each word out first_sent_bit (index 9) first, last_sent_bit last.
// - Loopback select low: data on line pair, loopback pair held true low.
// - Loopback select high: data on loopback pair, line pair held true low.
// - Bit clock is the reference clock multiplied by forty.
// - Word-rate clock goes out; coder derives the word strobe from it.
// - Rate choice high selects 531 Mbaud, low selects 1063 Mbaud.
// - One 10-bit word per word clock at the selected serial rate.
// - Signal-present output is the unclocked logic level of its input pair.
// - Word-rate clock output comes from the word clock pacing the shifter.
package tbs_pkg;

  // ==========================================================================
  // Word and timing constants
  localparam int unsigned WORD_W        = 10;
  localparam int unsigned CNT_W         = 4;
  localparam logic [3:0]  LAST_BIT_IDX  = 4'h9;
  localparam logic [3:0]  HALF_WORD_IDX = 4'h5;
  localparam int unsigned REF_MULT      = 40;
  localparam logic [7:0]  BITS_PER_REF  = 8'(REF_MULT);
  localparam logic [7:0]  RATIO_MAX     = 8'hff;
  localparam logic [WORD_W-1:0] IDLE_WORD = 10'h000;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic p;
    logic n;
  } tbs_pair_s;

  localparam tbs_pair_s PAIR_IDLE = '{p: 1'b0, n: 1'b1};

  typedef enum logic [1:0] {
    TBS_WAIT = 2'b01,
    TBS_RUN  = 2'b10
  } tbs_state_e;

endpackage : tbs_pkg

//--- bench/tbs_properties.sv
// Port checker for the ten-bit serial transmitter.
`timescale 1ns/1ps
module tbs_properties (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       rst_n,
  // Word side
  input wire logic                       word_strobe_clock,
  input wire logic [tbs_pkg::WORD_W-1:0] tx_word,
  input wire logic                       word_rate_clock_out,
  // Rate and reference
  input wire logic                       reference_clock,
  input wire logic                       rate_choice,
  input wire logic                       ref_locked,
  input wire logic [7:0]                 ref_ratio,
  // Serial side
  input wire logic                       loopback_select,
  input wire tbs_pkg::tbs_pair_s         line_out_pair,
  input wire tbs_pkg::tbs_pair_s         loopback_out_pair,
  input wire tbs_pkg::tbs_pair_s         signal_present_in_pair,
  input wire logic                       signal_present_out
);
  import tbs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Assertions
  AST_LINE_MODE: assert property (!loopback_select [*4] |=>
    loopback_out_pair == PAIR_IDLE && line_out_pair.n == !line_out_pair.p)
    else $error("line mode pairs wrong");
  AST_LOOP_MODE: assert property (loopback_select [*4] |=>
    line_out_pair == PAIR_IDLE && loopback_out_pair.n == !loopback_out_pair.p)
    else $error("loop mode pairs wrong");
  AST_ONE_IDLE: assert property (line_out_pair == PAIR_IDLE ||
    loopback_out_pair == PAIR_IDLE) else $error("both pairs active");
  AST_SIG_PRESENT: assert property (signal_present_out ==
    (signal_present_in_pair.p & ~signal_present_in_pair.n)) else $error("signal out wrong");
  AST_WORD_FULL: assert property ($rose(word_rate_clock_out) && !rate_choice
    && $past(rst_n, 4) |=> word_rate_clock_out [*4] ##1 !word_rate_clock_out [*5]
    ##1 word_rate_clock_out) else $error("full rate word period wrong");
  AST_WORD_HALF: assert property ($rose(word_rate_clock_out) && rate_choice
    && $past(rst_n, 4) |=> word_rate_clock_out [*8] ##1 word_rate_clock_out
    ##1 !word_rate_clock_out [*8] ##1 !word_rate_clock_out [*2] ##1 word_rate_clock_out)
    else $error("half rate word period wrong");
  AST_HALF_HOLD: assert property (rate_choice && !loopback_select && $past(rst_n, 4)
    && $changed(line_out_pair) |=> $stable(line_out_pair)) else $error("half bit short");
  AST_LOCK_RATIO: assert property (ref_locked |-> ref_ratio == BITS_PER_REF)
    else $error("lock without ratio");
  // ==========================================================================
  // Covers
  cover property ($rose(loopback_out_pair.p));
  cover property ($rose(ref_locked));
  cover property (rate_choice && $rose(word_rate_clock_out));
endmodule : tbs_properties

bind tbs_transmitter tbs_properties chk_u (.clk, .rst_n, .word_strobe_clock, .tx_word,
  .word_rate_clock_out, .reference_clock, .rate_choice, .ref_locked, .ref_ratio,
  .loopback_select, .line_out_pair, .loopback_out_pair, .signal_present_in_pair,
  .signal_present_out);

//--- bench/tbs_coder_model.sv
// Behavioural line coder: free-running word strobe and word source.
`timescale 1ns/1ps
module tbs_coder_model (
  // Word picked by the bench
  input  wire logic [tbs_pkg::WORD_W-1:0] next_word,
  // Parallel word interface
  output logic                            word_strobe_clock,
  output logic [tbs_pkg::WORD_W-1:0]      tx_word
);
  import tbs_pkg::*;
  initial begin
    word_strobe_clock = 1'b0;
    #7;
    forever #40 word_strobe_clock = ~word_strobe_clock;
  end
  always @(posedge word_strobe_clock) begin
    tx_word <= #2 next_word;
  end
endmodule : tbs_coder_model

//--- bench/tbs_transmitter_tb.sv
// Self-checking bench for the ten-bit serial transmitter.
`timescale 1ns/1ps
module tbs_transmitter_tb;
  import tbs_pkg::*;
  logic       clk, rst_n, wsc, refc, rate, loop, sdo, lock, wrc;
  logic [9:0] nw, txw, w;
  logic [7:0] ratio;
  logic [15:0] rs;
  tbs_pair_s  lp, bp, sp;
  int         fail_count = 0, check_count = 0, cyc = 0, i, p;
  tbs_transmitter dut_u (.clk(clk), .rst_n(rst_n), .word_strobe_clock(wsc), .tx_word(txw),
    .word_rate_clock_out(wrc), .reference_clock(refc), .rate_choice(rate),
    .ref_locked(lock), .ref_ratio(ratio), .loopback_select(loop), .line_out_pair(lp),
    .loopback_out_pair(bp), .signal_present_in_pair(sp), .signal_present_out(sdo));
  tbs_coder_model coder_u (.next_word(nw), .word_strobe_clock(wsc), .tx_word(txw));
  // ==========================================================================
  // Clocks and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // steady reference at one fortieth of the bit rate
  initial begin
    refc = 1'b0;
    #3;
    forever #200 refc = ~refc;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  // ==========================================================================
  // Helpers
  function automatic logic [15:0] xs(input logic [15:0] s);
    logic [15:0] t;
    t = s ^ (s << 7);
    t = t ^ (t >> 9);
    return t ^ (t << 8);
  endfunction : xs
  function automatic int exp_period(input logic r);
    return r ? 2 * WORD_W : WORD_W;
  endfunction : exp_period
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic cmp_w(input logic [9:0] g, input logic [9:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_w
  task automatic cmp_b(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_b
  task automatic grab(input logic lb, output logic [9:0] g);
    int n;
    // Bit 9 leaves with the rising word-rate clock.
    for (n = 0; n < 40 && wrc !== 1'b0; n++) tick(1);
    for (n = 0; n < 40 && wrc !== 1'b1; n++) tick(1);
    for (n = 9; n >= 0; n--) begin
      g[n] = lb ? bp.p : lp.p;
      tick(1);
    end
  endtask : grab
  task automatic period(output int q);
    int n;
    for (n = 0; n < 40 && wrc !== 1'b0; n++) tick(1);
    for (n = 0; n < 40 && wrc !== 1'b1; n++) tick(1);
    q = 0;
    for (n = 0; n < 40 && wrc !== 1'b0; n++) begin
      tick(1);
      q++;
    end
    for (n = 0; n < 40 && wrc !== 1'b1; n++) begin
      tick(1);
      q++;
    end
  endtask : period
  task automatic reset_with(input logic r, input int n);
    rst_n = 1'b0;
    rate = r;
    tick(n);
    rst_n = 1'b1;
    tick(5);
  endtask : reset_with
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  // ==========================================================================
  // Scenarios
  initial begin
    rst_n = 1'b0;
    rate = 1'b0;
    loop = 1'b0;
    sp = PAIR_IDLE;
    nw = IDLE_WORD;
    rs = 16'heca3;
    reset_with(1'b0, 10);
    for (i = 0; i < 11; i++) begin
      rs = xs(rs);
      nw = (i == 0) ? 10'h3ff : (i == 1) ? 10'h200 : (i == 2) ? 10'h001 : rs[9:0];
      loop = (i == 10);
      sp = tbs_pair_s'(rs[11:10]);
      tick(50);
      cmp_b(sdo, sp.p & ~sp.n);
      grab(loop, w);
      cmp_w(w, nw);
      cmp_w(10'(loop ? lp : bp), 10'(PAIR_IDLE));
    end
    loop = 1'b0;
    cmp_b(lock, 1'b1);
    cmp_w(10'(ratio), 10'(BITS_PER_REF));
    for (i = 0; i < 2; i++) begin
      reset_with(i[0], 30);
      period(p);
      cmp_w(10'(p), 10'(exp_period(i[0])));
    end
    results();
  end
endmodule : tbs_transmitter_tb
